// ---- hdl/fsm_monitor.sv ----
`timescale 1ns/1ps
// What this block does
// RULE_01 - Monitor works only when enable bit set; low oscillator then always runs.
// RULE_02 - Sample clock is low oscillator divided by sixty-four.
// RULE_03 - Activity latch set by device clock fall, cleared by sample clock rise.
// RULE_04 - Latch still clear at sample clock fall means clock failed.
// RULE_05 - Failure sets oscillator-fail flag, bit seven of flag register two.
// RULE_06 - Failure switches to internal oscillator; control register keeps old source.
// RULE_07 - Each fail-safe event clears watchdog count and postscaler.
// RULE_08 - Only primary and secondary sources are monitored.
// RULE_09 - Watchdog off does not stop low oscillator while monitor enabled.
// RULE_10 - Internal frequency after failover comes from three-bit select field.
// RULE_11 - Fail-safe ends only on reset or power-managed mode entry.
// RULE_12 - After reset run internal clock until primary clock is ready.
// RULE_13 - Primary ready: switch to it and set primary running status.
// RULE_14 - After switching back to primary, monitoring resumes.
// RULE_15 - Primary never ready: stay internal; control register keeps reset value. Code still switches to config_src on pm_mode_enter.
// RULE_16 - Switch to internal oscillator is glitch-free.
module fsm_monitor #(
   parameter int STARTUP_CNT = fsm_pkg::STARTUP_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic monitor_enable_config_bit,
   input wire logic watchdog_enable,
   input wire logic internal_low_osc,
   input wire logic device_clk_mon,
   input wire fsm_pkg::fsm_src_e config_src,
   input wire logic [fsm_pkg::FREQ_W-1:0] internal_freq_select,
   input wire logic primary_ready,
   input wire logic pm_mode_enter,
   input wire logic osc_fail_flag_clear,
   output logic low_osc_run,
   output logic osc_fail_flag,
   output logic [7:0] peripheral_irq_flags_two,
   output fsm_pkg::fsm_src_e clk_src_sel,
   output logic [fsm_pkg::FREQ_W-1:0] internal_freq_out,
   output logic primary_clock_running,
   output logic fail_safe_active,
   output logic watchdog_clear,
   output logic switch_pulse
);
   import fsm_pkg::*;

   // ********************************************
   // State
   // ********************************************
   typedef struct packed {
      logic [1:0] osc_sync;
      logic [1:0] dev_sync;
      logic osc_prev;
      logic dev_prev;
      logic [HALF_W-1:0] div_cnt;
      logic sample_clk;
      logic activity;
      fsm_state_e state;
      logic [15:0] start_cnt;
      logic flag;
      fsm_src_e src;
      logic [FREQ_W-1:0] freq;
      logic running;
      logic wd_clr;
      logic sw;
   } fsm_state_s;

   fsm_state_s q, d;
   // Kept apart from the state struct: it runs on the raw reset, the struct on its copy
   logic [1:0] rst_sync_q;
   logic rst_n_int;
   logic osc_rise;
   logic dev_fall;
   logic sample_rise;
   logic sample_fall;
   logic monitored;
   logic failed;

   // ********************************************
   // Reset release
   // ********************************************
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync_q[1];

   // ********************************************
   // Next state
   // ********************************************
   always_comb begin
      d = q;
      d.osc_sync = {q.osc_sync[0], internal_low_osc};
      d.dev_sync = {q.dev_sync[0], device_clk_mon};
      d.osc_prev = q.osc_sync[1];
      d.dev_prev = q.dev_sync[1];
      d.wd_clr = 1'b0;
      d.sw = 1'b0;
      osc_rise = q.osc_sync[1] & ~q.osc_prev;
      dev_fall = q.dev_prev & ~q.dev_sync[1];
      sample_rise = 1'b0;
      sample_fall = 1'b0;
      // Toggle every 32 oscillator edges gives a divide by 64
      if (osc_rise) begin
         if (q.div_cnt == HALF_W'(SAMPLE_HALF - 1)) begin // [RULE_02]
            d.div_cnt = '0;
            d.sample_clk = ~q.sample_clk;
            sample_rise = ~q.sample_clk;
            sample_fall = q.sample_clk;
         end else begin
            d.div_cnt = q.div_cnt + HALF_W'(1);
         end
      end
      // Only external sources are watched; internal failure goes unseen
      monitored = monitor_enable_config_bit && q.state == FSM_ST_RUN
                  && q.src != FSM_SRC_INTERNAL; // [RULE_01] [RULE_08] [RULE_14]
      // Clear first so a device edge in the same cycle still marks activity
      if (sample_rise) begin
         d.activity = 1'b0; // [RULE_03]
      end
      if (dev_fall) begin
         d.activity = 1'b1; // [RULE_03]
      end
      // An empty latch at the check means no device edge since the sample rise
      failed = monitored && sample_fall && !(q.activity | dev_fall); // [RULE_04]
      if (osc_fail_flag_clear) begin
         d.flag = 1'b0;
      end
      if (failed) begin
         d.flag = 1'b1; // [RULE_05]
      end
      d.freq = internal_freq_select; // [RULE_10]
      unique case (q.state)
         FSM_ST_STARTUP: begin
            if (q.start_cnt != '0) begin
               d.start_cnt = q.start_cnt - 16'(1);
            end else if (primary_ready) begin
               d.state = FSM_ST_RUN; // [RULE_12]
               d.src = config_src;
               d.running = (config_src == FSM_SRC_PRIMARY); // [RULE_13]
               d.sw = 1'b1;
               d.activity = 1'b1;
            end
            // Never ready: stay internal with reset status unless pm_mode_enter switches to config_src [RULE_15]
            if (pm_mode_enter) begin
               d.state = FSM_ST_RUN;
               d.src = config_src;
               d.activity = 1'b1;
               d.sw = 1'b1;
            end
         end
         FSM_ST_RUN: begin
            if (failed) begin
               d.state = FSM_ST_FAILSAFE; // [RULE_06]
               d.wd_clr = 1'b1; // [RULE_07]
               d.sw = 1'b1;
            end
         end
         FSM_ST_FAILSAFE: begin
            if (pm_mode_enter) begin
               d.state = FSM_ST_RUN; // [RULE_11]
               d.src = config_src;
               d.running = (config_src == FSM_SRC_PRIMARY);
               d.activity = 1'b1;
               d.sw = 1'b1;
            end
         end
         default: begin
            d.state = FSM_ST_STARTUP;
         end
      endcase
   end

   // ********************************************
   // Registers
   // ********************************************
   always_ff @(posedge clk_sys or negedge rst_n_int) begin
      if (!rst_n_int) begin
         q.osc_sync <= 2'h0;
         q.dev_sync <= 2'h0;
         q.osc_prev <= 1'b0;
         q.dev_prev <= 1'b0;
         q.div_cnt <= '0;
         q.sample_clk <= 1'b0;
         q.activity <= 1'b1;
         q.state <= FSM_ST_STARTUP;
         q.start_cnt <= 16'(STARTUP_CNT);
         q.flag <= 1'b0;
         q.src <= FSM_SRC_INTERNAL;
         q.freq <= FREQ_RESET;
         q.running <= 1'b0;
         q.wd_clr <= 1'b0;
         q.sw <= 1'b0;
      end else begin
         q.osc_sync <= d.osc_sync;
         q.dev_sync <= d.dev_sync;
         q.osc_prev <= d.osc_prev;
         q.dev_prev <= d.dev_prev;
         q.div_cnt <= d.div_cnt;
         q.sample_clk <= d.sample_clk;
         q.activity <= d.activity;
         q.state <= d.state;
         q.start_cnt <= d.start_cnt;
         q.flag <= d.flag;
         q.src <= d.src;
         q.freq <= d.freq;
         q.running <= d.running;
         q.wd_clr <= d.wd_clr;
         q.sw <= d.sw;
      end
   end

   // ********************************************
   // Outputs
   // ********************************************
   // Oscillator held on by the monitor regardless of the watchdog
   assign low_osc_run = monitor_enable_config_bit | watchdog_enable; // [RULE_01] [RULE_09]
   assign osc_fail_flag = q.flag;
   assign peripheral_irq_flags_two = FLAGS_RESET | (8'(q.flag) << FLAG_BIT); // [RULE_05]
   // Actual source goes internal in fail-safe; the status copy stays stale
   assign clk_src_sel = (q.state == FSM_ST_RUN) ? q.src : FSM_SRC_INTERNAL; // [RULE_06]
   assign internal_freq_out = q.freq;
   assign primary_clock_running = q.running; // [RULE_06]
   assign fail_safe_active = (q.state == FSM_ST_FAILSAFE);
   assign watchdog_clear = q.wd_clr; // [RULE_07]
   // Registered switch pulse; the glitch-free mux itself must park low between sources
   assign switch_pulse = q.sw; // [RULE_16]
endmodule : fsm_monitor

// ---- hdl/fsm_pkg.sv ----
package fsm_pkg;
   // ********************************************
   // Sizes and counts
   // ********************************************
   localparam int SAMPLE_DIV = 64;
   localparam int SAMPLE_HALF = SAMPLE_DIV / 2;
   localparam int HALF_W = 5;
   localparam int FREQ_W = 3;
   localparam int FLAG_BIT = 7;
   localparam int STARTUP_CYCLES = 1024;
   localparam logic [FREQ_W-1:0] FREQ_RESET = 3'h0;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   // ********************************************
   // Device clock source selection and monitor states
   // ********************************************
   typedef enum logic [1:0] {FSM_SRC_INTERNAL, FSM_SRC_PRIMARY, FSM_SRC_SECONDARY} fsm_src_e;
   typedef enum logic [1:0] {FSM_ST_STARTUP, FSM_ST_RUN, FSM_ST_FAILSAFE} fsm_state_e;
endpackage : fsm_pkg

// ---- verification/fsm_monitor_properties.sv ----
`timescale 1ns/1ps
module fsm_props import fsm_pkg::*; #(
   parameter int STARTUP_CNT = 4
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic monitor_enable_config_bit,
   input wire logic watchdog_enable,
   input wire logic pm_mode_enter,
   input wire logic low_osc_run,
   input wire logic osc_fail_flag,
   input wire logic [7:0] peripheral_irq_flags_two,
   input wire fsm_pkg::fsm_src_e clk_src_sel,
   input wire logic primary_clock_running,
   input wire logic fail_safe_active,
   input wire logic watchdog_clear,
   input wire logic switch_pulse
);
   // ********************************
   // Output relations
   // ********************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   osc_keep_a: assert property (
      low_osc_run == (monitor_enable_config_bit | watchdog_enable)) else $error("osc run");
   flag_map_a: assert property (
      peripheral_irq_flags_two == {osc_fail_flag, 7'h00}) else $error("flag map");
   fail_act_a: assert property ($rose(fail_safe_active) |->
      osc_fail_flag && watchdog_clear && clk_src_sel == FSM_SRC_INTERNAL) else $error("failover");
   wd_once_a: assert property (
      watchdog_clear |=> !watchdog_clear && fail_safe_active) else $error("wd clear");
   fs_hold_a: assert property (
      fail_safe_active && !pm_mode_enter |=> fail_safe_active) else $error("fs dropped");
   no_int_a: assert property (clk_src_sel == FSM_SRC_INTERNAL &&
      !fail_safe_active |=> !$rose(fail_safe_active)) else $error("internal trip");
   glitch_a: assert property (
      $changed(clk_src_sel) |-> switch_pulse) else $error("switch pulse");
   off_trip_a: assert property (
      !monitor_enable_config_bit [*4] |=> !$rose(fail_safe_active)) else $error("off trip");
   cover property ($rose(fail_safe_active));
   cover property ($fell(fail_safe_active));
   cover property ($rose(primary_clock_running));
endmodule : fsm_props

bind fsm_monitor fsm_props #(.STARTUP_CNT(STARTUP_CNT)) u_fsm_props (.*);

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
   import fsm_pkg::*;
   typedef struct packed {logic flag; fsm_src_e src; logic fs;} fsm_exp_s;
   logic clk_sys = 0, rstn = 0, monitor_enable_config_bit = 1, watchdog_enable = 0;
   logic internal_low_osc = 0, device_clk_mon = 0, primary_ready = 0, pm_mode_enter = 0;
   logic osc_fail_flag_clear = 0, dev_run = 1, low_osc_run, osc_fail_flag;
   logic primary_clock_running, fail_safe_active, watchdog_clear, switch_pulse;
   logic [7:0] peripheral_irq_flags_two;
   logic [FREQ_W-1:0] internal_freq_select = 3'h0, internal_freq_out;
   fsm_src_e config_src = FSM_SRC_PRIMARY, clk_src_sel;
   fsm_src_e srcs[4] = '{FSM_SRC_PRIMARY, FSM_SRC_SECONDARY, FSM_SRC_PRIMARY, FSM_SRC_INTERNAL};
   int oc = 0, dc = 0, err_total = 0, compares = 0;
   fsm_exp_s exp_q[$];
   fsm_monitor #(.STARTUP_CNT(4)) u_fsm_monitor (.*);
   // ********************************
   // Clocks and checking
   // ********************************
   initial forever #2.5 clk_sys = !clk_sys;
   // Low osc period 16 cycles, so one sample period is 1024 cycles
   always @(posedge clk_sys) begin
      oc <= (oc + 1) % 8;
      dc <= (dc + 1) % 5;
      if (oc == 7) internal_low_osc <= !internal_low_osc;
      if (dc == 4 && dev_run) device_clk_mon <= !device_clk_mon;
   end
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (exp !== got) begin
         err_total++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out
   always @(posedge clk_sys) begin
      if (watchdog_clear === 1'b1) begin
         check("queued", 8'h1, 8'(exp_q.size() != 0));
         if (exp_q.size() != 0) begin
            check("flag", 8'(exp_q[0].flag), 8'(osc_fail_flag));
            check("source", 8'(exp_q[0].src), 8'(clk_src_sel));
            check("fail safe", 8'(exp_q[0].fs), 8'(fail_safe_active));
            void'(exp_q.pop_front());
         end
         check("irq reg", 8'(8'h01 << FLAG_BIT), peripheral_irq_flags_two);
         check("switch", 8'h1, 8'(switch_pulse));
      end
   end
   initial begin
      #200000;
      err_total++;
      close_out();
   end
   // ********************************
   // Cases: primary, secondary, disabled, internal
   // ********************************
   initial begin
      void'($urandom(32'he751));
      for (int i = 0; i < 4; i++) begin
         rstn <= 1'b0;
         primary_ready <= 1'b0;
         dev_run <= 1'b1;
         config_src <= srcs[i];
         monitor_enable_config_bit <= (i != 2);
         watchdog_enable <= 1'($urandom);
         internal_freq_select <= 3'($urandom);
         repeat (16) @(posedge clk_sys);
         rstn <= 1'b1;
         repeat (20) @(posedge clk_sys);
         check("startup src", 8'(FSM_SRC_INTERNAL), 8'(clk_src_sel));
         check("startup run", 8'h0, 8'(primary_clock_running));
         check("freq", 8'(internal_freq_select), 8'(internal_freq_out));
         if (i != 2) check("osc run", 8'h1, 8'(low_osc_run));
         primary_ready <= 1'b1;
         repeat (20) @(posedge clk_sys);
         check("running", 8'(srcs[i] == FSM_SRC_PRIMARY), 8'(primary_clock_running));
         check("run src", 8'(srcs[i]), 8'(clk_src_sel));
         repeat (2100) @(posedge clk_sys);
         check("no trip", 8'h0, 8'(fail_safe_active));
         if (i < 2) exp_q.push_back('{1'b1, FSM_SRC_INTERNAL, 1'b1});
         dev_run <= 1'b0;
         for (int n = 0; n < 3000 && fail_safe_active !== 1'b1; n++) @(posedge clk_sys);
         check("failover", 8'(i < 2), 8'(fail_safe_active));
         if (i < 2) begin
            check("status kept", 8'(i == 0), 8'(primary_clock_running));
            osc_fail_flag_clear <= 1'b1;
            dev_run <= 1'b1;
            @(posedge clk_sys);
            osc_fail_flag_clear <= 1'b0;
            repeat (2100) @(posedge clk_sys);
            check("flag clear", 8'h0, 8'(osc_fail_flag));
            check("fs held", 8'h1, 8'(fail_safe_active));
            pm_mode_enter <= 1'b1;
            @(posedge clk_sys);
            pm_mode_enter <= 1'b0;
            repeat (4) @(posedge clk_sys);
            check("fs ended", 8'h0, 8'(fail_safe_active));
         end
      end
      check("leftover", 8'h0, 8'(exp_q.size()));
      close_out();
   end
endmodule : tb
